// >>> smst_top.sv
`timescale 1ns/1ps
// Overview of operation
// - master idle: a transmit buffer write starts a new byte transfer
// - empty shifter takes the pending transmit byte
// - after eight bits, byte goes to receive buffer and next byte loads
// - one shifter: one bit out for every bit in
// - all four polarity and phase modes, master and slave
// - master halves the double-rate input clock into a 50% bit clock
// - master drives data out and no slave select
// - master interrupt on transmit empty after the first buffer write, or on complete with irq_on_complete set
// - slave interrupt on receive full, or on complete with irq_on_complete set
// - status read clears all flags but transmit empty and receive full
// - buffer write clears transmit empty; buffer read clears receive full
// - only the matching access clears status; set status holds interrupt
// - slave takes data and bit clock from the outside master
// - slave select comes from a pin; may stay low in all four modes
// - select never gates slave output; output holds next first bit
// - slave buffer moves follow the master's clock edges
module smst_top
  import smst_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire smst_cfg_t    i_cfg,
  input  wire logic         i_tx_wr,
  input  wire logic [7:0]   i_tx_data,
  input  wire logic         i_rx_rd,
  input  wire logic         i_status_rd,
  input  wire logic         i_bitclk_x2,
  input  wire logic         i_miso,
  input  wire logic         i_sclk,
  input  wire logic         i_mosi,
  input  wire logic         i_ss_n,
  output logic              o_mosi,
  output logic              o_sclk,
  output logic              o_miso,
  output logic [7:0]        o_rx_data,
  output smst_status_t      o_status,
  output logic              o_irq,
  output logic              o_busy
);

  logic [SMST_PIN_W-1:0] pins_s;
  logic                  x2_prev_q;
  logic                  sclk_prev_q;
  logic                  tick;
  logic                  s_rise;
  logic                  s_fall;
  logic                  slave_edges_ok;
  logic                  lead_m;
  logic                  trail_m;
  logic                  m_sclk;
  logic                  lead;
  logic                  trail;
  logic                  cpha;
  logic                  cpol;
  logic                  sample_ev;
  logic                  shift_ev;
  logic                  din;
  logic                  byte_done;
  logic                  load_idle;
  logic [7:0]            rx_next;
  logic [7:0]            sh_q;
  logic                  sh_empty_q;
  logic [3:0]            cnt_q;
  logic                  s_bit_q;
  logic [7:0]            txb_q;
  logic [7:0]            rxb_q;
  logic                  primed_q;
  smst_status_t          st_q;
  smst_eng_t             eng_q;
  logic                  m_run;
  logic                  irq_src;
  logic                  mosi_q;
  logic                  miso_q;
  logic                  sclk_q;
  logic                  irq_q;
  logic                  busy_q;

  smst_sync #(
    .WIDTH   (SMST_PIN_W),
    .RST_VAL (SMST_PIN_RST)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_bitclk_x2, i_miso, i_sclk, i_mosi, i_ss_n}),
    .o_sync    (pins_s)
  );

  assign cpol = i_cfg.mode[SMST_MODE_CPOL];
  assign cpha = i_cfg.mode[SMST_MODE_CPHA];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      x2_prev_q   <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      x2_prev_q   <= pins_s[SMST_PIN_X2];
      sclk_prev_q <= pins_s[SMST_PIN_SCLK];
    end
  end

  assign tick   = pins_s[SMST_PIN_X2] && !x2_prev_q;
  assign s_rise = pins_s[SMST_PIN_SCLK] && !sclk_prev_q;
  assign s_fall = !pins_s[SMST_PIN_SCLK] && sclk_prev_q;
  // select only masks edges; it never resets the shifter or the output
  assign slave_edges_ok = i_cfg.enable && i_cfg.slave && !pins_s[SMST_PIN_SS_N];

  // master bit clock: one toggle per rising edge of the double-rate input
  smst_clkdiv u_div (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (i_cfg.enable && !i_cfg.slave),
    .i_tick    (tick),
    .i_run     (m_run),
    .i_cpol    (cpol),
    .o_sclk    (m_sclk),
    .o_lead    (lead_m),
    .o_trail   (trail_m)
  );

  // leading edge leaves the idle level; phase picks the sampling edge
  always_comb begin
    if (i_cfg.slave) begin
      lead  = slave_edges_ok && (cpol ? s_fall : s_rise);
      trail = slave_edges_ok && (cpol ? s_rise : s_fall);
      din   = pins_s[SMST_PIN_MOSI];
    end else begin
      lead  = lead_m && i_cfg.enable;
      trail = trail_m && i_cfg.enable;
      din   = pins_s[SMST_PIN_MISO];
    end
  end

  assign sample_ev = cpha ? trail : lead;
  assign shift_ev  = cpha ? lead : trail;
  assign byte_done = sample_ev && (cnt_q == SMST_LAST_BIT);
  assign rx_next   = smst_shift_in(sh_q, din, i_cfg.lsb_first);
  assign load_idle = i_cfg.enable && sh_empty_q && !st_q.tx_empty && (cnt_q == 4'h0)
                     && !sample_ev;

  // slave edges come from the master's clock, so buffer moves follow them
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sh_q       <= SMST_BYTE_RST;
      sh_empty_q <= 1'b1;
      cnt_q      <= 4'h0;
      s_bit_q    <= 1'b0;
    end else if (!i_cfg.enable) begin
      cnt_q <= 4'h0;
    end else if (byte_done) begin
      cnt_q <= 4'h0;
      if (!st_q.tx_empty) begin
        sh_q       <= txb_q;
        sh_empty_q <= 1'b0;
      end else begin
        sh_q       <= rx_next;
        sh_empty_q <= 1'b1;
      end
    end else if (sample_ev) begin
      s_bit_q <= din;
      cnt_q   <= cnt_q + 4'h1;
    end else if (shift_ev && (cnt_q != 4'h0)) begin
      sh_q <= smst_shift_in(sh_q, s_bit_q, i_cfg.lsb_first);
    end else if (load_idle) begin
      sh_q       <= txb_q;
      sh_empty_q <= 1'b0;
    end
  end

  // a write in the same cycle as a move keeps the buffer marked full
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      txb_q          <= SMST_BYTE_RST;
      st_q.tx_empty  <= SMST_STATUS_RST.tx_empty;
      primed_q       <= 1'b0;
    end else if (i_tx_wr) begin
      txb_q         <= i_tx_data;
      st_q.tx_empty <= 1'b0;
      primed_q      <= 1'b1;
    end else if ((byte_done && !st_q.tx_empty) || load_idle) begin
      st_q.tx_empty <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rxb_q        <= SMST_BYTE_RST;
      st_q.rx_full <= SMST_STATUS_RST.rx_full;
    end else if (byte_done) begin
      rxb_q        <= rx_next;
      st_q.rx_full <= 1'b1;
    end else if (i_rx_rd) begin
      st_q.rx_full <= 1'b0;
    end
  end

  // on overrun the new byte overwrites the old one; firmware reads the flag as lost data
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q.complete <= SMST_STATUS_RST.complete;
      st_q.overrun  <= SMST_STATUS_RST.overrun;
    end else begin
      if (byte_done) begin
        st_q.complete <= 1'b1;
      end else if (i_status_rd) begin
        st_q.complete <= 1'b0;
      end
      if (byte_done && st_q.rx_full && !i_rx_rd) begin
        st_q.overrun <= 1'b1;
      end else if (i_status_rd) begin
        st_q.overrun <= 1'b0;
      end
    end
  end

  assign m_run = (eng_q == SMST_RUN);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      eng_q <= SMST_IDLE;
    end else if (!i_cfg.enable || i_cfg.slave) begin
      eng_q <= SMST_IDLE;
    end else begin
      case (eng_q)
        SMST_IDLE: begin
          if (!sh_empty_q) begin
            eng_q <= SMST_RUN;
          end
        end
        SMST_RUN: begin
          if (byte_done && st_q.tx_empty) begin
            eng_q <= SMST_IDLE;
          end
        end
        default: begin
          eng_q <= SMST_IDLE;
        end
      endcase
    end
  end

  // no select output exists; a general pin under firmware does that job
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      sclk_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      mosi_q <= !i_cfg.slave && smst_out_bit(sh_q, i_cfg.lsb_first);
      miso_q <= i_cfg.slave && smst_out_bit(sh_q, i_cfg.lsb_first);
      sclk_q <= i_cfg.slave ? cpol : m_sclk;
      busy_q <= m_run || (cnt_q != 4'h0);
    end
  end

  // level interrupt: it stays up until the source flag is cleared
  always_comb begin
    if (i_cfg.irq_on_complete) begin
      irq_src = st_q.complete;
    end else if (i_cfg.slave) begin
      irq_src = st_q.rx_full;
    end else begin
      irq_src = st_q.tx_empty && primed_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= i_cfg.enable && i_cfg.int_en && irq_src;
    end
  end

  assign o_mosi    = mosi_q;
  assign o_miso    = miso_q;
  assign o_sclk    = sclk_q;
  assign o_rx_data = rxb_q;
  assign o_status  = st_q;
  assign o_irq     = irq_q;
  assign o_busy    = busy_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence seq_idle_write;
    i_cfg.enable && !i_cfg.slave && (eng_q == SMST_IDLE) && sh_empty_q && i_tx_wr;
  endsequence

  sequence seq_done_reload;
    byte_done && !st_q.tx_empty && !i_tx_wr;
  endsequence

  a_master_start: assert property (seq_idle_write ##1 $stable(i_cfg) |-> ##[1:2] m_run)
    else $error("master did not start after buffer write");

  a_shift_load: assert property (load_idle && !i_tx_wr |=> !sh_empty_q && st_q.tx_empty)
    else $error("pending byte not moved into empty shifter");

  a_byte_capture: assert property (byte_done |=> st_q.rx_full && st_q.complete
                                   && (o_rx_data == $past(rx_next)))
    else $error("received byte not stored after eighth bit");

  a_bit_count: assert property (sample_ev && (cnt_q != SMST_LAST_BIT) && i_cfg.enable
                                |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit count did not advance on sample");

  a_clk_halving: assert property (tick && m_run && i_cfg.enable && !i_cfg.slave
                                  ##1 $stable(i_cfg) |-> ##1 o_sclk != $past(o_sclk, 1))
    else $error("bit clock did not toggle on input clock edge");

  a_status_clear: assert property (i_status_rd && !byte_done
                                   |=> !st_q.complete && !st_q.overrun)
    else $error("status read left a flag set");

  a_tx_flag_clear: assert property (i_tx_wr |=> !st_q.tx_empty)
    else $error("buffer write did not clear transmit empty");

  a_rx_flag_clear: assert property (i_rx_rd && !byte_done |=> !st_q.rx_full)
    else $error("buffer read did not clear receive full");

  a_irq_hold: assert property (i_cfg.enable && i_cfg.int_en && i_cfg.irq_on_complete
                               && st_q.complete && !i_status_rd && $stable(i_cfg)
                               |=> o_irq [*2])
    else $error("interrupt dropped while status still set");

  a_next_first_bit: assert property (seq_done_reload ##1 (i_cfg.slave && $stable(i_cfg)
                                     && !sample_ev && !shift_ev)
                                     |=> o_miso == smst_out_bit($past(txb_q, 2),
                                                                i_cfg.lsb_first))
    else $error("slave output does not hold the next first bit");

endmodule

// >>> smst_pkg.sv
package smst_pkg;

  localparam int unsigned SMST_DATA_W      = 8;
  localparam logic [3:0]  SMST_LAST_BIT    = 4'h7;
  localparam int unsigned SMST_PIN_W       = 5;
  // pin vector order: x2 clock, miso, sclk, mosi, select (active low)
  localparam int unsigned SMST_PIN_X2      = 4;
  localparam int unsigned SMST_PIN_MISO    = 3;
  localparam int unsigned SMST_PIN_SCLK    = 2;
  localparam int unsigned SMST_PIN_MOSI    = 1;
  localparam int unsigned SMST_PIN_SS_N    = 0;
  localparam logic [4:0]  SMST_PIN_RST     = 5'h01;
  // mode bit 1 is clock polarity, mode bit 0 is clock phase
  localparam int unsigned SMST_MODE_CPOL   = 1;
  localparam int unsigned SMST_MODE_CPHA   = 0;
  localparam logic [7:0]  SMST_BYTE_RST    = 8'h00;

  typedef struct packed {
    logic       enable;
    logic       slave;
    logic [1:0] mode;
    logic       lsb_first;
    logic       int_en;
    logic       irq_on_complete;
  } smst_cfg_t;

  typedef struct packed {
    logic overrun;
    logic complete;
    logic rx_full;
    logic tx_empty;
  } smst_status_t;

  localparam smst_status_t SMST_STATUS_RST = '{overrun: 1'b0, complete: 1'b0,
                                               rx_full: 1'b0, tx_empty: 1'b1};

  typedef enum logic [0:0] {
    SMST_IDLE,
    SMST_RUN
  } smst_eng_t;

  function automatic logic [7:0] smst_shift_in(input logic [7:0] sh,
                                              input logic       bit_in,
                                              input logic       lsb_first);
    smst_shift_in = lsb_first ? {bit_in, sh[7:1]} : {sh[6:0], bit_in};
  endfunction

  function automatic logic smst_out_bit(input logic [7:0] sh,
                                        input logic       lsb_first);
    smst_out_bit = lsb_first ? sh[0] : sh[7];
  endfunction

endpackage

// >>> smst_sync.sv
`timescale 1ns/1ps
module smst_sync
  import smst_pkg::*;
#(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  initial begin
    if (WIDTH < 1) $error("smst_sync width must be at least one");
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_q <= RST_VAL;
    end else begin
      out_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
    end
  end

  assign o_sync = out_q;

endmodule

// >>> smst_clkdiv.sv
`timescale 1ns/1ps
module smst_clkdiv
  import smst_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_enable,
  input  wire logic i_tick,
  input  wire logic i_run,
  input  wire logic i_cpol,
  output logic      o_sclk,
  output logic      o_lead,
  output logic      o_trail
);

  logic sclk_q;
  logic lead_q;
  logic trail_q;
  logic step;

  // an unfinished half period always completes, so the line parks at idle
  assign step = i_tick && (i_run || (sclk_q != i_cpol));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q  <= 1'b0;
      lead_q  <= 1'b0;
      trail_q <= 1'b0;
    end else if (!i_enable) begin
      sclk_q  <= i_cpol;
      lead_q  <= 1'b0;
      trail_q <= 1'b0;
    end else begin
      sclk_q  <= step ? ~sclk_q : sclk_q;
      lead_q  <= step && (sclk_q == i_cpol);
      trail_q <= step && (sclk_q != i_cpol);
    end
  end

  assign o_sclk  = sclk_q;
  assign o_lead  = lead_q;
  assign o_trail = trail_q;

endmodule

// >>> smst_peer.sv
`timescale 1ns/1ps
module smst_peer
  import smst_pkg::*;
#(
  parameter int X2_HALF = 125,
  parameter int SK_HALF = 300
) (
  input  wire logic [1:0] i_mode,
  input  wire logic       i_lsb,
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic       i_miso,
  output logic            o_miso,
  output logic            o_x2,
  output logic            o_sclk,
  output logic            o_mosi,
  output logic            o_ss_n
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] got;
  int         ns;
  int         pos;
  int         hi_ns;
  realtime    t_rise;

  // the double-rate source runs free; the offset keeps its edges off i_clk edges
  initial begin
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
    tx_q = 8'h00;
    ns = 0;
    pos = 0;
    o_x2 = 1'b0;
    #7;
    forever #(X2_HALF) o_x2 = ~o_x2;
  end

  assign o_miso = tx_q[i_lsb ? pos : 7 - pos];

  // far slave: the master gives no select, so every bit clock edge counts
  always @(i_sclk) begin
    if ((i_sclk != i_mode[SMST_MODE_CPOL]) != i_mode[SMST_MODE_CPHA]) begin
      got = i_lsb ? {i_mosi, got[7:1]} : {got[6:0], i_mosi};
      ns++;
      if (ns == 8) begin
        rx_q = got;
        tx_q = ~got;
        ns = 0;
      end
    end else begin
      pos = ns;
    end
  end

  always @(posedge i_sclk) t_rise = $realtime;
  always @(negedge i_sclk) hi_ns = int'($realtime - t_rise);

  task automatic load(input logic [7:0] b);
    tx_q = b;
    ns = 0;
    pos = 0;
  endtask

  // far master: bit clock stands still outside the frame
  task automatic xfer(input logic [7:0] b, input logic hold_sel, output logic [7:0] r);
    o_sclk = i_mode[SMST_MODE_CPOL];
    #(SK_HALF) o_ss_n = 1'b0;
    #(SK_HALF);
    for (int i = 0; i < 8; i++) begin
      if (!i_mode[0]) o_mosi = i_lsb ? b[i] : b[7-i];
      if (!i_mode[0]) r = i_lsb ? {i_miso, r[7:1]} : {r[6:0], i_miso};
      o_sclk = ~o_sclk;
      if (i_mode[0]) o_mosi = i_lsb ? b[i] : b[7-i];
      #(SK_HALF) o_sclk = ~o_sclk;
      if (i_mode[0]) r = i_lsb ? {i_miso, r[7:1]} : {r[6:0], i_miso};
      #(SK_HALF);
    end
    o_mosi = ~o_mosi;
    o_ss_n = ~hold_sel;
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench import smst_pkg::*;;
  logic         i_clk, i_sys_rst, i_tx_wr, i_rx_rd, i_status_rd;
  smst_cfg_t    i_cfg;
  logic [7:0]   i_tx_data, o_rx_data, a, b, r, p;
  logic         x2, p_miso, p_sclk, p_mosi, p_ss_n;
  logic         o_mosi, o_sclk, o_miso, o_irq, o_busy;
  smst_status_t o_status;
  int           miscompares, total_checks, cycles;

  smst_top DUT (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_cfg       (i_cfg),
    .i_tx_wr     (i_tx_wr),
    .i_tx_data   (i_tx_data),
    .i_rx_rd     (i_rx_rd),
    .i_status_rd (i_status_rd),
    .i_bitclk_x2 (x2),
    .i_miso      (p_miso),
    .i_sclk      (p_sclk),
    .i_mosi      (p_mosi),
    .i_ss_n      (p_ss_n),
    .o_mosi      (o_mosi),
    .o_sclk      (o_sclk),
    .o_miso      (o_miso),
    .o_rx_data   (o_rx_data),
    .o_status    (o_status),
    .o_irq       (o_irq),
    .o_busy      (o_busy)
  );

  smst_peer peer (
    .i_mode (i_cfg.mode),
    .i_lsb  (i_cfg.lsb_first),
    .i_sclk (o_sclk),
    .i_mosi (o_mosi),
    .i_miso (o_miso),
    .o_miso (p_miso),
    .o_x2   (x2),
    .o_sclk (p_sclk),
    .o_mosi (p_mosi),
    .o_ss_n (p_ss_n)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang ends the run through the same closing report
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // k: 0 buffer write, 1 receive read, 2 status read; r holds what was read
  task automatic fw(input int k, input logic [7:0] b, output logic [7:0] r);
    @(posedge i_clk);
    i_tx_data   <= b;
    i_tx_wr     <= (k == 0);
    i_rx_rd     <= (k == 1);
    i_status_rd <= (k == 2);
    #1 r = (k == 1) ? o_rx_data : 8'(o_status);
    @(posedge i_clk);
    {i_tx_wr, i_rx_rd, i_status_rd} <= 3'h0;
  endtask

  task automatic wait_st(input int b);
    for (int n = 0; n < 2000 && o_status[b] !== 1'b1; n++) tick(1);
    chk_bit("status wait", 1'b1, o_status[b]);
  endtask

  // settings only change while the block is off
  task automatic cfg(input logic sl, input logic [1:0] m, input logic lsb, input logic oc);
    @(posedge i_clk);
    i_cfg.enable <= 1'b0;
    @(posedge i_clk);
    i_cfg <= '{1'b0, sl, m, lsb, 1'b1, oc};
    @(posedge i_clk);
    i_cfg.enable <= 1'b1;
    tick(6);
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_cfg = '0;
    {i_tx_wr, i_rx_rd, i_status_rd} = 3'h0;
    i_tx_data = 8'h00;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    tick(1);
    chk_byte("reset status", 8'h01, 8'(o_status));
    chk_bit("reset irq", 1'b0, o_irq);
    for (int m = 0; m < 4; m++) begin
      a = 8'h96 ^ 8'(m);
      cfg(1'b0, 2'(m), m[0], m[1]);
      peer.load(8'hc3 + 8'(m));
      fw(0, a, r);
      tick(4);
      chk_bit("tx_empty", 1'b1, o_status.tx_empty);
      chk_bit("irq", !m[1], o_irq);
      fw(0, ~a, r);
      tick(3);
      chk_bit("irq", 1'b0, o_irq);
      chk_bit("busy", 1'b1, o_busy);
      wait_st(1);
      fw(1, 8'h00, r);
      chk_byte("rx", 8'hc3 + 8'(m), r);
      chk_byte("peer rx", a, peer.rx_q);
      fw(2, 8'h00, r);
      chk_byte("status", 8'h05, r);
      tick(3);
      chk_byte("status", 8'h01, 8'(o_status));
      chk_bit("irq", !m[1], o_irq);
      wait_st(1);
      fw(1, 8'h00, r);
      chk_byte("rx", ~a, r);
      chk_byte("peer rx", ~a, peer.rx_q);
      tick(40);
      chk_bit("sclk idle", m[1], o_sclk);
      chk_bit("busy", 1'b0, o_busy);
      if (m == 0) chk_bit("duty", 1'b1, peer.hi_ns > 224 && peer.hi_ns < 276);
      fw(2, 8'h00, r);
    end
    // the byte loaded after a slave transfer stays in the shifter for the next one
    a = 8'h4d;
    for (int m = 0; m < 4; m++) begin
      cfg(1'b1, 2'(m), m[1], m[0]);
      if (m == 0) fw(0, a, r);
      tick(8);
      chk_bit("miso first", m[1] ? a[0] : a[7], o_miso);
      chk_bit("mosi off", 1'b0, o_mosi);
      b = ~a ^ 8'(m << 4);
      fw(0, b, r);
      peer.xfer(8'h71 + 8'(m), m == 3, p);
      chk_byte("master rx", a, p);
      wait_st(1);
      tick(3);
      chk_bit("irq", 1'b1, o_irq);
      fw(2, 8'h00, r);
      tick(3);
      chk_bit("irq", !m[0], o_irq);
      fw(1, 8'h00, r);
      chk_byte("rx", 8'h71 + 8'(m), r);
      tick(3);
      chk_bit("irq", 1'b0, o_irq);
      chk_bit("miso next", m[1] ? b[0] : b[7], o_miso);
      a = b;
    end
    results();
  end
endmodule
